// ### design/wpk_defines.svh
`ifndef WPK_DEFINES_SVH
`define WPK_DEFINES_SVH

// ============================================================
// Word layout
`define WPK_NWORDS 4
`define WPK_TX_SLOT_W 11
`define WPK_TX_BUS_W 44
`define WPK_PMA_W 22
`define WPK_RX_SLOT_W 16
`define WPK_RX_BUS_W 64
`define WPK_RAW_W 10
`define WPK_DK_W 9
`define WPK_RM_W 3
`define WPK_UFLOW_DK 9'h1FE

// ============================================================
// Rate-match status codes on the receive word
`define WPK_RMC_NORMAL 2'b00
`define WPK_RMC_DELETE 2'b01
`define WPK_RMC_INSERT 2'b10
`define WPK_RMC_OVERFLOW 2'b11

// ============================================================
// Register map (byte addresses)
`define WPK_ADDR_W 8
`define WPK_OFF_CTRL 8'h00
`define WPK_OFF_STATUS 8'h04
`define WPK_OFF_EVENTS 8'h08

// ============================================================
// Control fields
`define WPK_CTRL_W 4
`define WPK_CTRL_DBL 0
`define WPK_CTRL_BSER 1
`define WPK_CTRL_BYP 2
`define WPK_CTRL_RCFG 3
`define WPK_CTRL_RST 4'h0

// ============================================================
// Sticky event fields
`define WPK_EV_W 5
`define WPK_EV_DEL 0
`define WPK_EV_INS 1
`define WPK_EV_UFL 2
`define WPK_EV_OFL 3
`define WPK_EV_CV 4
`define WPK_EV_RST 5'h00

// ============================================================
// AXI responses
`define WPK_RESP_OKAY 2'b00
`define WPK_RESP_SLVERR 2'b10

`endif

// ### design/wpk_pkg.sv
`include "wpk_defines.svh"

package wpk_pkg;

  // ============================================================
  // Rate-match event reported by the coding sublayer per word
  typedef enum logic [2:0] {
    WPK_RM_NORMAL = 3'h0,
    WPK_RM_DELETE = 3'h1,
    WPK_RM_INSERT = 3'h2,
    WPK_RM_OVERFLOW = 3'h3,
    WPK_RM_UNDERFLOW = 3'h4
  } wpk_rm_event_e;

  // Serializer phase, Gray along LOW -> HIGH -> LOW
  typedef enum logic {
    WPK_PH_LOW = 1'b0,
    WPK_PH_HIGH = 1'b1
  } wpk_tx_phase_e;

  // Which of the four word slots carry data for a configuration
  function automatic logic [3:0] wpk_used_mask(input logic dbl, input logic bser);
    wpk_used_mask = {dbl & bser, bser, dbl, 1'b1};
  endfunction : wpk_used_mask

  // Two-bit rate-match status; underflow shares the insertion code
  function automatic logic [1:0] wpk_rm_code(input logic [2:0] ev);
    case (ev)
      WPK_RM_DELETE: wpk_rm_code = `WPK_RMC_DELETE;
      WPK_RM_INSERT: wpk_rm_code = `WPK_RMC_INSERT;
      WPK_RM_UNDERFLOW: wpk_rm_code = `WPK_RMC_INSERT;
      WPK_RM_OVERFLOW: wpk_rm_code = `WPK_RMC_OVERFLOW;
      default: wpk_rm_code = `WPK_RMC_NORMAL;
    endcase
  endfunction : wpk_rm_code

endpackage : wpk_pkg

// ### design/wpk_rx_if.sv
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Receive side bundle between the packer top and the word formatter
interface wpk_rx_if;
  logic dbl;
  logic bser;
  logic byp;
  logic rcfg;
  logic [35:0] dk;
  logic [39:0] raw;
  logic [3:0] cv;
  logic [3:0] aln;
  logic [3:0] de;
  logic [3:0] pd;
  logic [3:0] rd;
  logic [11:0] rm_ev;
  logic [63:0] word;
  logic [4:0] events;

  modport top (output dbl, bser, byp, rcfg, dk, raw, cv, aln, de, pd, rd, rm_ev, input word, events);
  modport fmt (input dbl, bser, byp, rcfg, dk, raw, cv, aln, de, pd, rd, rm_ev, output word, events);
endinterface : wpk_rx_if

`default_nettype wire

// ### design/wpk_rx_format.sv
`timescale 1ns/100ps
`default_nettype none

module wpk_rx_format (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Coding sublayer fields in, formatted bus out
  wpk_rx_if.fmt rx
);
  import wpk_pkg::*;

  logic [3:0] used;
  logic [63:0] dec_bus;
  logic [39:0] raw_bus;
  logic [63:0] next_word;
  logic [3:0] ev_del;
  logic [3:0] ev_ins;
  logic [3:0] ev_ufl;
  logic [3:0] ev_ofl;
  logic [3:0] ev_cv;
  logic [4:0] next_events;
  logic [63:0] word;
  logic [4:0] events;

  assign used = wpk_used_mask(rx.dbl, rx.bser);

  // ============================================================
  // Per-word field assembly
  genvar i;
  generate
    for (i = 0; i < `WPK_NWORDS; i++) begin : g_word
      wire [2:0] ev = rx.rm_ev[`WPK_RM_W*i +: `WPK_RM_W];
      wire ufl = (ev == WPK_RM_UNDERFLOW);
      // Underflow is told apart from insertion only by the filler value
      wire [8:0] dk = ufl ? `WPK_UFLOW_DK : rx.dk[`WPK_DK_W*i +: `WPK_DK_W];
      wire [15:0] dec = {rx.rd[i], wpk_rm_code(ev), rx.pd[i], rx.de[i], rx.aln[i], rx.cv[i], dk};
      wire [9:0] raw = rx.raw[`WPK_RAW_W*i +: `WPK_RAW_W];
      wire [15:0] rcf = {3'h0, rx.pd[i], rx.de[i], rx.aln[i], raw};
      assign dec_bus[`WPK_RX_SLOT_W*i +: `WPK_RX_SLOT_W] = used[i] ? (rx.byp ? rcf : dec) : 16'h0000;
      assign raw_bus[`WPK_RAW_W*i +: `WPK_RAW_W] = used[i] ? raw : 10'h000;
      assign ev_del[i] = used[i] & (ev == WPK_RM_DELETE);
      assign ev_ins[i] = used[i] & (ev == WPK_RM_INSERT);
      assign ev_ufl[i] = used[i] & ufl;
      assign ev_ofl[i] = used[i] & (ev == WPK_RM_OVERFLOW);
      assign ev_cv[i] = used[i] & ~rx.byp & rx.cv[i];
    end
  endgenerate

  // Bypass without reconfiguration packs bare symbols at the fabric width
  assign next_word = (rx.byp & ~rx.rcfg) ? {24'h000000, raw_bus} : dec_bus;
  assign next_events = {|ev_cv, |ev_ofl, |ev_ufl, |ev_ins, |ev_del};

  // Every cycle yields a word; there is no qualifier to drop one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word <= 64'h0;
      events <= `WPK_EV_RST;
    end else begin
      word <= next_word;
      events <= next_events;
    end
  end

  assign rx.word = word;
  assign rx.events = events;

endmodule : wpk_rx_format

`default_nettype wire

// ### design/wpk_top.sv
// Design decisions made here: the address map and the AXI4-Lite slave port.
`include "wpk_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module wpk_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [`WPK_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`WPK_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Fabric transmit words
  input wire logic [`WPK_TX_BUS_W-1:0] tx_parallel_data,
  output logic tx_take,
  // Serial-sublayer transmit words
  output logic [`WPK_PMA_W-1:0] pma_tx_data,
  // Coding sublayer receive fields, four words each
  input wire logic [35:0] pcs_rx_dk,
  input wire logic [39:0] pcs_rx_raw,
  input wire logic [3:0] pcs_rx_code_viol,
  input wire logic [3:0] pcs_rx_aligned,
  input wire logic [3:0] pcs_rx_disp_err,
  input wire logic [3:0] pcs_rx_pat_det,
  input wire logic [3:0] pcs_rx_run_disp,
  input wire logic [11:0] pcs_rx_rm_event,
  // Fabric receive words
  output logic [`WPK_RX_BUS_W-1:0] rx_parallel_data
);
  import wpk_pkg::*;

  // ============================================================
  // Declarations
  logic [`WPK_CTRL_W-1:0] ctrl;
  logic [`WPK_EV_W-1:0] events;
  logic aw_held;
  logic w_held;
  logic [`WPK_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wpk_tx_phase_e phase;
  wpk_tx_phase_e next_phase;
  logic [`WPK_PMA_W-1:0] tx_hi;
  logic [`WPK_PMA_W-1:0] pma_q;
  logic [`WPK_PMA_W-1:0] next_pma;
  logic [`WPK_TX_BUS_W-1:0] tx_masked;
  logic [3:0] tx_used;
  logic [2:0] tx_count;

  wpk_rx_if rxb ();

  // ============================================================
  // Configuration decode
  // A new setting applies from the next edge; words in flight are not
  // drained, so the fabric should change mode only while idle.
  wire cfg_dbl = ctrl[`WPK_CTRL_DBL];
  wire cfg_bser = ctrl[`WPK_CTRL_BSER];
  wire cfg_byp = ctrl[`WPK_CTRL_BYP];
  wire cfg_rcfg = ctrl[`WPK_CTRL_RCFG];

  // ============================================================
  // AXI4-Lite slave: handshakes
  // Address and data are caught independently so the master may
  // present them in either order; one write is serviced at a time.
  assign awready = ~aw_held & ~bvalid_q;
  assign wready = ~w_held & ~bvalid_q;
  assign arready = ~rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  wire aw_fire = awvalid & awready;
  wire w_fire = wvalid & wready;
  wire ar_fire = arvalid & arready;
  wire wr_do = aw_held & w_held & ~bvalid_q;

  // Write address decode
  wire wr_hit_ctrl = (awaddr_q == `WPK_OFF_CTRL);
  wire wr_hit_stat = (awaddr_q == `WPK_OFF_STATUS);
  wire wr_hit_ev = (awaddr_q == `WPK_OFF_EVENTS);
  wire wr_mapped = wr_hit_ctrl | wr_hit_stat | wr_hit_ev;
  wire wr_ctrl = wr_do & wr_hit_ctrl & wstrb_q[0];
  wire wr_ev = wr_do & wr_hit_ev & wstrb_q[0];
  wire [`WPK_EV_W-1:0] ev_clear = wr_ev ? wdata_q[`WPK_EV_W-1:0] : `WPK_EV_RST;

  // Read address decode; status shows live serializer phase and slot count
  // The mux looks at araddr directly: arready drops while rvalid stands,
  // so the address cannot move under a pending answer.
  wire rd_hit_ctrl = (araddr == `WPK_OFF_CTRL);
  wire rd_hit_stat = (araddr == `WPK_OFF_STATUS);
  wire rd_hit_ev = (araddr == `WPK_OFF_EVENTS);
  wire rd_mapped = rd_hit_ctrl | rd_hit_stat | rd_hit_ev;
  wire [31:0] stat_word = {28'h0000000, tx_count, phase};
  wire [31:0] rd_mux = rd_hit_ctrl ? {28'h0000000, ctrl} :
                       rd_hit_stat ? stat_word :
                       rd_hit_ev ? {27'h0000000, events} : 32'h00000000;

  // Capture write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (aw_fire) begin
      aw_held <= 1'b1;
      awaddr_q <= awaddr;
    end else if (wr_do) begin
      aw_held <= 1'b0;
    end
  end

  // Capture write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (w_fire) begin
      w_held <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_do) begin
      w_held <= 1'b0;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `WPK_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? `WPK_RESP_OKAY : `WPK_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read answer, registered on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `WPK_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_mapped ? `WPK_RESP_OKAY : `WPK_RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ============================================================
  // Control and sticky event registers
  // A new event in the clearing cycle survives: set wins over clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `WPK_CTRL_RST;
      events <= `WPK_EV_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wdata_q[`WPK_CTRL_W-1:0];
      end
      events <= (events & ~ev_clear) | rxb.events;
    end
  end

  // ============================================================
  // Transmit slot masking
  // Used slot mask and count; the count is shown in the status register
  // so software can confirm the width it has selected.
  assign tx_used = wpk_used_mask(cfg_dbl, cfg_bser);
  assign tx_count = 3'(tx_used[0]) + 3'(tx_used[1]) + 3'(tx_used[2]) + 3'(tx_used[3]);

  // Eleven-bit slots from bit zero; the byte and control flag sit
  // inside each slot and pass through untouched
  genvar i;
  generate
    for (i = 0; i < `WPK_NWORDS; i++) begin : g_tx
      assign tx_masked[`WPK_TX_SLOT_W*i +: `WPK_TX_SLOT_W] =
        tx_used[i] ? tx_parallel_data[`WPK_TX_SLOT_W*i +: `WPK_TX_SLOT_W] : 11'h000;
    end
  endgenerate

  // ============================================================
  // Byte serializer
  // The low half carries words 0 and 1, the high half words 2 and 3,
  // so single-word mode with the serializer sends word 0 then word 2.
  assign tx_take = ~cfg_bser | (phase == WPK_PH_LOW);

  always_comb begin
    next_phase = WPK_PH_LOW;
    next_pma = tx_masked[`WPK_PMA_W-1:0];
    case (phase)
      WPK_PH_LOW: begin
        next_phase = cfg_bser ? WPK_PH_HIGH : WPK_PH_LOW;
        next_pma = tx_masked[`WPK_PMA_W-1:0];
      end
      WPK_PH_HIGH: begin
        // If the serializer was just switched off, tx_take is already high
        // and the fresh word must leave now; the held upper half is dropped.
        next_phase = WPK_PH_LOW;
        next_pma = cfg_bser ? tx_hi : tx_masked[`WPK_PMA_W-1:0];
      end
      default: begin
        next_phase = WPK_PH_LOW;
        next_pma = tx_masked[`WPK_PMA_W-1:0];
      end
    endcase
  end

  // Serializer phase and upper half holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= WPK_PH_LOW;
      tx_hi <= 22'h000000;
      pma_q <= 22'h000000;
    end else begin
      phase <= next_phase;
      pma_q <= next_pma;
      if (tx_take) begin
        tx_hi <= tx_masked[`WPK_TX_BUS_W-1:`WPK_PMA_W];
      end
    end
  end

  // Registered so the serial side sees a settled word for a whole cycle
  assign pma_tx_data = pma_q;

  // ============================================================
  // Receive formatting
  // The fabric cannot stall this path, so no ready input exists.
  // The field layout lives in its own module so it can be checked apart
  // from the register bus and the serializer.
  assign rxb.dbl = cfg_dbl;
  assign rxb.bser = cfg_bser;
  assign rxb.byp = cfg_byp;
  assign rxb.rcfg = cfg_rcfg;
  assign rxb.dk = pcs_rx_dk;
  assign rxb.raw = pcs_rx_raw;
  assign rxb.cv = pcs_rx_code_viol;
  assign rxb.aln = pcs_rx_aligned;
  assign rxb.de = pcs_rx_disp_err;
  assign rxb.pd = pcs_rx_pat_det;
  assign rxb.rd = pcs_rx_run_disp;
  assign rxb.rm_ev = pcs_rx_rm_event;

  wpk_rx_format u_rx_format (
    .aclk(aclk),
    .aresetn(aresetn),
    .rx(rxb)
  );

  assign rx_parallel_data = rxb.word;

endmodule : wpk_top

`default_nettype wire

// ### verification/wpk_checker.sv
`timescale 1ns/100ps
`default_nettype none

module wpk_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Transmit path
  input wire logic [43:0] tx_parallel_data,
  input wire logic tx_take,
  input wire logic [21:0] pma_tx_data
);
  // ============================================================
  // Timing relations on the ports
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_take_alt: assert property (!tx_take |=> tx_take)
    else $error("serializer skipped a take");
  chk_word0_pass: assert property (tx_take |=> pma_tx_data[10:0] == $past(tx_parallel_data[10:0]))
    else $error("word 0 not passed");
  // The upper half is held from the take, so word 2 follows it exactly
  chk_word2_pass: assert property (tx_take ##1 !tx_take |=>
    pma_tx_data[10:0] == $past(tx_parallel_data[32:22], 2))
    else $error("word 2 not passed");
  chk_read_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_write_resp: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response timing");
  chk_busy_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  chk_ar_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while busy");

  cov_ser: cover property (tx_take ##1 !tx_take ##1 tx_take);
  cov_read: cover property (rvalid && rready);
  cov_slverr: cover property (bvalid && bresp == 2'h2);
endmodule : wpk_checker

`default_nettype wire

// ### verification/wpk_fabric_model.sv
`timescale 1ns/100ps
`default_nettype none

module wpk_fabric_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Transmit words toward the block
  input wire logic tx_take,
  input wire logic [31:0] rnd,
  output logic [43:0] tx_parallel_data,
  // Receive words from the block
  input wire logic [63:0] rx_parallel_data,
  output logic [31:0] rx_words
);
  // ============================================================
  // New words only when taken; byte low, control flag in bit 8
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_parallel_data <= 44'h0;
    end else if (tx_take) begin
      tx_parallel_data <= {2'h0, rnd[3:0], rnd[31:27], 2'h0, rnd[26:18], 2'h0, rnd[17:9], 2'h0, rnd[8:0]};
    end
  end

  // Sink never stalls, so a word is consumed on every cycle
  always @(posedge aclk) begin
    rx_words <= aresetn ? rx_words + {31'h0, |rx_parallel_data | 1'h1} : 32'h0;
  end
endmodule : wpk_fabric_model

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "wpk_defines.svh"
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, a); end end

module tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, tx_take, chk_on = 1'h0, rx_on = 1'h0, v = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, s = 32'h43, rdata;
  logic [1:0] bresp, rresp;
  logic [43:0] tx_parallel_data;
  logic [21:0] pma_tx_data, e_pma, hi = 22'h0;
  logic [63:0] rx_parallel_data, e_rx;
  logic [35:0] dk = 36'h0;
  logic [39:0] raw = 40'h0;
  logic [3:0] cv = 4'h0, al = 4'h0, de = 4'h0, pd = 4'h0, rd = 4'h0, cfg = 4'h0, st = 4'hF;
  logic [11:0] ev = 12'h0;
  logic [4:0] exp_ev = 5'h0;
  logic [3:0] modes [4] = '{4'h3, 4'hF, 4'h7, 4'h0};
  int errors = 0, n_checks = 0;

  always #5 aclk = ~aclk;

  wpk_top wpk_top_i (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
    .wstrb(st), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
    .rdata, .rresp, .tx_parallel_data, .tx_take, .pma_tx_data, .pcs_rx_dk(dk), .pcs_rx_raw(raw),
    .pcs_rx_code_viol(cv), .pcs_rx_aligned(al), .pcs_rx_disp_err(de), .pcs_rx_pat_det(pd),
    .pcs_rx_run_disp(rd), .pcs_rx_rm_event(ev), .rx_parallel_data);
  wpk_fabric_model wpk_fabric_model_i (.aclk, .aresetn, .tx_take, .rnd(s), .tx_parallel_data,
    .rx_parallel_data, .rx_words());

  // ============================================================
  // Stimulus helpers
  function automatic logic [31:0] lf(input logic [31:0] x);
    lf = {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lf

  task automatic final_report();
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // Ready is sampled mid-cycle so the edge update never races the decision
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ao, wo, b;
    logic [1:0] r;
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      ao = awready;
      wo = wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ao) awvalid <= 1'h0;
      if (wo) wvalid <= 1'h0;
      if (b) break;
    end
    bready <= 1'h0;
    if (k == 50) begin
      errors++;
      final_report();
    end else `CHK("bresp", er, r)
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk, input logic [1:0] er);
    logic ao, b;
    logic [1:0] r;
    logic [31:0] d;
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      ao = arready;
      b = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ao) arvalid <= 1'h0;
      if (b) break;
    end
    rready <= 1'h0;
    if (k == 50) begin
      errors++;
      final_report();
    end else begin
      `CHK("rresp", er, r)
      `CHK("rdata", e, d & mk)
    end
  endtask : rdc

  // Random coding-sublayer fields while the receive run is on
  always @(posedge aclk) begin : pcs_drv
    logic [31:0] a, b, c;
    a = lf(s);
    b = lf(a);
    c = lf(b);
    s <= c;
    dk <= rx_on ? {a, b[3:0]} : 36'h0;
    raw <= rx_on ? {b, a[7:0]} : 40'h0;
    {cv, al, de, pd} <= rx_on ? c[15:0] : 16'h0;
    rd <= rx_on ? c[19:16] : 4'h0;
    for (int i = 0; i < 4; i++) ev[3*i+:3] <= rx_on ? 3'(a[8*i+:8] % 5) : 3'h0;
  end

  // ============================================================
  // Reference model, evaluated on pre-edge values
  always @(posedge aclk) begin : model
    logic [3:0] m;
    logic [2:0] q;
    m = {cfg[0] & cfg[1], cfg[1], cfg[0], 1'h1};
    if (tx_take) begin
      e_pma = {cfg[0] ? tx_parallel_data[21:11] : 11'h0, tx_parallel_data[10:0]}; // slots
      hi = {m[3] ? tx_parallel_data[43:33] : 11'h0, m[2] ? tx_parallel_data[32:22] : 11'h0};
    end else begin
      e_pma = hi;
    end
    e_rx = 64'h0;
    for (int i = 0; i < 4; i++) begin
      q = ev[3*i+:3];
      if (m[i] && !cfg[2]) begin
        e_rx[16*i+:16] = {rd[i], q == 3'h4 ? 2'h2 : q[1:0], pd[i], de[i], al[i], cv[i],
          q == 3'h4 ? 9'h1FE : dk[9*i+:9]}; // fields
      end else if (m[i] && cfg[3]) begin
        e_rx[16*i+:16] = {3'h0, pd[i], de[i], al[i], raw[10*i+:10]}; // raw fields
      end else if (m[i]) begin
        e_rx[10*i+:10] = raw[10*i+:10]; // packed
      end
      // Rate-match events count in every mode, code violations only when decoding
      if (chk_on && m[i]) exp_ev = exp_ev | {cv[i] & !cfg[2], q == 3'h3, q == 3'h4, q == 3'h2, q == 3'h1};
    end
    v = chk_on;
  end

  always @(negedge aclk) begin
    if (v) begin
      `CHK("pma_tx_data", e_pma, pma_tx_data) // tx slots
      `CHK("rx_parallel_data", e_rx, rx_parallel_data) // every word
    end
  end

  // ============================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(8'h00, 32'h0, 32'hF, `WPK_RESP_OKAY);
    rdc(8'h04, 32'h2, 32'hE, `WPK_RESP_OKAY);
    rdc(8'h08, 32'h0, 32'h1F, `WPK_RESP_OKAY);
    rdc(8'h0C, 32'h0, 32'hFFFFFFFF, `WPK_RESP_SLVERR);
    wr(8'h0C, 32'hF, `WPK_RESP_SLVERR);
    wr(8'h04, 32'hF, `WPK_RESP_OKAY);
    rdc(8'h04, 32'h2, 32'hE, `WPK_RESP_OKAY);
    // A write with the low byte lane off is answered but changes nothing
    st <= 4'h0;
    wr(8'h00, 32'hF, `WPK_RESP_OKAY);
    st <= 4'hF;
    rdc(8'h00, 32'h0, 32'hF, `WPK_RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, 32'(c), `WPK_RESP_OKAY);
      cfg <= 4'(c);
      repeat (2) @(posedge aclk);
      chk_on <= 1'h1;
      repeat (12) @(posedge aclk);
      chk_on <= 1'h0;
      rdc(8'h04, 32'((c == 3 ? 4 : (c == 0 ? 1 : 2)) * 2), 32'hE, `WPK_RESP_OKAY); // used words
    end
    // Decode, bypass with and without reconfig, then single word
    foreach (modes[j]) begin
      wr(8'h08, 32'h1F, `WPK_RESP_OKAY);
      wr(8'h00, 32'(modes[j]), `WPK_RESP_OKAY);
      cfg <= modes[j];
      exp_ev = 5'h0;
      repeat (2) @(posedge aclk);
      chk_on <= 1'h1;
      rx_on <= 1'h1;
      repeat (40) @(posedge aclk);
      rx_on <= 1'h0;
      repeat (3) @(posedge aclk);
      chk_on <= 1'h0;
      rdc(8'h08, 32'(exp_ev), 32'h1F, `WPK_RESP_OKAY); // events
      wr(8'h08, 32'h1F, `WPK_RESP_OKAY);
      rdc(8'h08, 32'h0, 32'h1F, `WPK_RESP_OKAY);
    end
    final_report();
  end
endmodule : tb_top

bind wpk_top wpk_checker wpk_checker_i (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .tx_parallel_data, .tx_take, .pma_tx_data);

`default_nettype wire
